// file: rtl/wid_params.svh
// constants for the wake-up and interrupt dispatch block
`ifndef WID_PARAMS_SVH
`define WID_PARAMS_SVH
// clock period in ns (50 MHz)
`define WID_CLK_NS 20
// oscillator start-up period in ns (16 ms)
`define WID_OSC_STARTUP_NS 16000000
// extra clocks after the oscillator start-up period
`define WID_RC_EXTRA_CYC 8
`define WID_XTAL_EXTRA_CYC 510
// start-up counter width
`define WID_CNT_W 20
// source counts
`define WID_N_PWM 3
`define WID_N_GPT 3
`define WID_N_EXT 10
`define WID_N_PORT 4
`endif

// file: rtl/wid_pkg.sv
// types shared by the wake-up and interrupt dispatch block
`include "wid_params.svh"
package wid_pkg;

  typedef enum logic [1:0] {
    WID_MODE_NORMAL = 2'b00,
    WID_MODE_GREEN  = 2'b01,
    WID_MODE_IDLE   = 2'b10,
    WID_MODE_SLEEP  = 2'b11
  } wid_mode_t;

  typedef enum logic {
    WID_ST_RUN     = 1'b0,
    WID_ST_STARTUP = 1'b1
  } wid_state_t;

  // one-cycle event strobes from the peripherals
  typedef struct packed {
    logic base_timer;
    logic [`WID_N_PWM-1:0] pwm_period;
    logic [`WID_N_PWM-1:0] pwm_duty;
    logic [`WID_N_GPT-1:0] gp_timer;
    logic watch_timer;
    logic [`WID_N_EXT-1:0] ext_pin;
    logic [`WID_N_PORT-1:0] port_change;
    logic comparator;
    logic converter;
    logic serial_periph;
    logic two_wire;
    logic voltage_detect;
    logic uart_tx_done;
    logic uart_rx_full;
    logic uart_rx_error;
    logic watchdog_timer;
    logic low_volt_reset;
  } wid_evt_t;

  // per-source interrupt masks, 1 lets the interrupt through
  typedef struct packed {
    logic base_timer;
    logic [`WID_N_PWM-1:0] pwm_period;
    logic [`WID_N_PWM-1:0] pwm_duty;
    logic [`WID_N_GPT-1:0] gp_timer;
    logic watch_timer;
    logic [`WID_N_EXT-1:0] ext_pin;
    logic [`WID_N_PORT-1:0] port_change;
    logic comparator;
    logic converter;
    logic serial_periph;
    logic two_wire;
    logic voltage_detect;
    logic uart_tx_done;
    logic uart_rx_full;
    logic uart_rx_error;
  } wid_mask_t;

  // per-source wake enables
  typedef struct packed {
    logic [`WID_N_EXT-1:0] ext_pin;
    logic [`WID_N_PORT-1:0] port_change;
    logic comparator;
    logic converter;
    logic serial_periph;
    logic two_wire;
    logic voltage_detect;
  } wid_wake_t;

  typedef struct packed {
    logic base_timer_counter;
    logic [`WID_N_GPT-1:0] gp_timer_counter;
    logic osc_crystal;
  } wid_cfg_t;

  // request to the core sequencer, at most one bit set
  typedef struct packed {
    logic reset;
    logic vector;
    logic resume;
  } wid_act_t;

endpackage : wid_pkg

// file: rtl/wid_startup_timer.sv
// start-up delay down-counter for the wake-up path
`timescale 1ns/1ps
`include "wid_params.svh"
module wid_startup_timer #(
  parameter int unsigned CNT_W = `WID_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] load_val,
  // status
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_r <= load_val;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = (cnt_r != '0);
  // last counted cycle; the owner acts on the edge that ends it
  assign done = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : wid_startup_timer

// file: rtl/wid_dispatch.sv
// wake-up and interrupt dispatch decision logic
// Function
// - enabled event resumes when interrupts off, vectors when on; clear mask blocks interrupt
// - base timer in timer use never wakes from sleep; masked wakes idle, interrupts
// - base timer in counter use with mask wakes sleep and idle, interrupts too
// - pwm period match with mask wakes idle only, interrupts in green and normal
// - pwm duty match with mask wakes idle only, interrupts in green and normal
// - general timers in timer use with mask wake idle, not sleep; interrupt
// - general timers in counter use with mask wake sleep and idle; interrupt
// - watch timer never wakes sleep; idle with interrupts on wakes and vectors
// - external pin wakes only with wake enable; interrupts only with its mask
// - wake enable with clear mask wakes and resumes regardless of interrupt state
// - port change gated by own wake enable and mask; disabled never wakes
// - comparator change wakes with wake enable; interrupts only with its mask
// - converter completion wakes with wake enable; interrupts only with its mask
// - serial slave data wakes with wake enable; interrupts only with its mask
// - voltage detector wakes with wake enable; interrupts only with its mask
// - uart events never wake; interrupt in green and normal only with mask
// - low-voltage reset wakes then resets from low power, resets directly otherwise
// - watchdog time-out wakes then resets from low power, resets directly otherwise
// - wake completes after start-up period plus 8 clocks rc or 510 crystal
`timescale 1ns/1ps
`include "wid_params.svh"
module wid_dispatch #(
  parameter int unsigned OSC_STARTUP_CYC = (`WID_OSC_STARTUP_NS + `WID_CLK_NS - 1) / `WID_CLK_NS,
  parameter int unsigned CNT_W = `WID_CNT_W
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // reset pin, active low, asynchronous to clk
  input wire logic rst_pin_n,
  // core state
  input wire wid_pkg::wid_mode_t power_mode,
  input wire logic global_irq_on,
  input wire wid_pkg::wid_cfg_t cfg,
  // peripheral events and gating
  input wire wid_pkg::wid_evt_t evt,
  input wire wid_pkg::wid_wake_t wake_en,
  input wire wid_pkg::wid_mask_t irq_mask,
  // requests to the core sequencer
  output wid_pkg::wid_act_t action,
  output logic wake_done,
  output logic startup_busy
);
  import wid_pkg::*;

  // ==========================================================
  // helpers
  // reset beats vector, vector beats resume
  function automatic wid_act_t pick_act(input logic rst, input logic irq, input logic ev, input logic gon);
    wid_act_t a;
    a = '0;
    if (rst) begin
      a.reset = 1'b1;
    end else if (ev && irq && gon) begin
      a.vector = 1'b1;
    end else if (ev) begin
      a.resume = 1'b1;
    end
    return a;
  endfunction : pick_act

  function automatic wid_act_t merge_act(input wid_act_t a, input wid_act_t b);
    return pick_act(a.reset | b.reset, a.vector | b.vector, |a | |b, 1'b1);
  endfunction : merge_act

  localparam logic [CNT_W-1:0] LOAD_RC = CNT_W'(OSC_STARTUP_CYC + `WID_RC_EXTRA_CYC);
  localparam logic [CNT_W-1:0] LOAD_XTAL = CNT_W'(OSC_STARTUP_CYC + `WID_XTAL_EXTRA_CYC);

  // ==========================================================
  // reset pin synchroniser
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic pin_fall;

  // only the second stage is read; the first may still be settling
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else if (ce) begin
      pin_meta_r <= rst_pin_n;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // one request per press; a held pin does not flood the sequencer
  assign pin_fall = pin_prev_r & ~pin_sync_r;

  // ==========================================================
  // source decode
  logic low_power;
  logic any_reset;
  logic wake_en_hit;
  logic wake_sleep;
  logic wake_idle;
  logic wake_hit;
  logic masked_any;

  assign low_power = (power_mode == WID_MODE_IDLE) || (power_mode == WID_MODE_SLEEP);
  assign any_reset = evt.watchdog_timer | evt.low_volt_reset | pin_fall;

  // wake-enable sources wake without regard to their interrupt mask
  assign wake_en_hit = (|(evt.ext_pin & wake_en.ext_pin))
    | (|(evt.port_change & wake_en.port_change))
    | (evt.comparator & wake_en.comparator)
    | (evt.converter & wake_en.converter)
    | (evt.serial_periph & wake_en.serial_periph)
    | (evt.two_wire & wake_en.two_wire)
    | (evt.voltage_detect & wake_en.voltage_detect);

  // only counters clocked from outside keep running in sleep
  assign wake_sleep = wake_en_hit
    | (evt.base_timer & irq_mask.base_timer & cfg.base_timer_counter)
    | (|(evt.gp_timer & irq_mask.gp_timer & cfg.gp_timer_counter));

  assign wake_idle = wake_sleep
    | (evt.base_timer & irq_mask.base_timer)
    | (|(evt.pwm_period & irq_mask.pwm_period))
    | (|(evt.pwm_duty & irq_mask.pwm_duty))
    | (|(evt.gp_timer & irq_mask.gp_timer))
    | (evt.watch_timer & irq_mask.watch_timer & global_irq_on);

  // uart events appear here only, so they never wake
  assign masked_any = (|(evt[$bits(wid_evt_t)-1 -: $bits(wid_mask_t)] & irq_mask));

  assign wake_hit = (power_mode == WID_MODE_SLEEP) ? wake_sleep : wake_idle;

  // ==========================================================
  // decision state machine
  wid_state_t st_r;
  wid_state_t st_nxt;
  wid_act_t pend_r;
  wid_act_t pend_nxt;
  wid_act_t act_nxt;
  wid_act_t now_act;
  logic done_nxt;
  logic start_tmr;
  logic tmr_done;
  logic [CNT_W-1:0] load_val;

  assign load_val = cfg.osc_crystal ? LOAD_XTAL : LOAD_RC;

  always_comb begin
    st_nxt = st_r;
    pend_nxt = pend_r;
    act_nxt = '0;
    done_nxt = 1'b0;
    start_tmr = 1'b0;
    now_act = '0;
    unique case (st_r)
      WID_ST_RUN: begin
        if (low_power) begin
          now_act = pick_act(any_reset, masked_any, wake_hit, global_irq_on);
          if (|now_act) begin
            st_nxt = WID_ST_STARTUP;
            pend_nxt = now_act;
            start_tmr = 1'b1;
          end
        end else begin
          act_nxt = pick_act(any_reset, masked_any, masked_any, global_irq_on);
        end
      end
      WID_ST_STARTUP: begin
        // events during the start-up wait join the pending request
        pend_nxt = merge_act(pend_r, pick_act(any_reset, masked_any, wake_hit, global_irq_on));
        if (tmr_done) begin
          st_nxt = WID_ST_RUN;
          act_nxt = pend_nxt;
          pend_nxt = '0;
          done_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= WID_ST_RUN;
      pend_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      action <= '0;
      wake_done <= 1'b0;
    end else if (ce) begin
      action <= act_nxt;
      wake_done <= done_nxt;
    end
  end

  wid_startup_timer #(
    .CNT_W(CNT_W)
  ) u_startup_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(start_tmr),
    .load_val(load_val),
    .busy(),
    .done(tmr_done)
  );

  assign startup_busy = (st_r == WID_ST_STARTUP);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic solo;
  logic run_ce;
  logic [CNT_W-1:0] wait_cnt_r;
  logic [CNT_W-1:0] exp_r;

  assign solo = $onehot(evt) && pin_fall == 1'b0;
  assign run_ce = ce && st_r == WID_ST_RUN;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_cnt_r <= '0;
      exp_r <= '0;
    end else if (ce) begin
      if (start_tmr) begin
        wait_cnt_r <= '0;
        exp_r <= load_val;
      end else if (st_r == WID_ST_STARTUP) begin
        wait_cnt_r <= wait_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  sequence s_wait_end;
    ce && st_r == WID_ST_STARTUP && tmr_done;
  endsequence

  // a wake decision starts the counted wait at the edge that takes it
  sequence s_wake_taken;
    run_ce && start_tmr;
  endsequence

  chk_normal_vector: assert property (run_ce && power_mode == WID_MODE_NORMAL && solo && evt.uart_tx_done
    && irq_mask.uart_tx_done && global_irq_on |=> action.vector) else $error("masked event did not vector");
  chk_bt_timer_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.base_timer
    && !cfg.base_timer_counter |=> st_r == WID_ST_RUN && action == '0) else $error("base timer woke sleep");
  chk_bt_count_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.base_timer
    && cfg.base_timer_counter && irq_mask.base_timer |=> st_r == WID_ST_STARTUP) else $error("counter no wake");
  chk_pwm_period_idle: assert property (run_ce && power_mode == WID_MODE_IDLE && solo
    && |(evt.pwm_period & irq_mask.pwm_period) |=> st_r == WID_ST_STARTUP) else $error("pwm period no wake");
  chk_pwm_duty_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && |evt.pwm_duty
    |=> st_r == WID_ST_RUN) else $error("pwm duty woke sleep");
  chk_gpt_timer_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo
    && |(evt.gp_timer & ~cfg.gp_timer_counter) |=> st_r == WID_ST_RUN) else $error("timer woke sleep");
  chk_gpt_count_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo
    && |(evt.gp_timer & cfg.gp_timer_counter & irq_mask.gp_timer) |=> pend_r != '0) else $error("no wake");
  chk_watch_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.watch_timer
    |=> st_r == WID_ST_RUN) else $error("watch timer woke sleep");
  chk_ext_pin_gate: assert property (run_ce && low_power && solo && |evt.ext_pin
    && !(|(evt.ext_pin & wake_en.ext_pin)) |=> st_r == WID_ST_RUN) else $error("pin woke without enable");
  chk_wake_resume: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.comparator
    && wake_en.comparator && !irq_mask.comparator |=> pend_r.resume) else $error("unmasked wake did not resume");
  chk_port_no_wake: assert property (run_ce && low_power && solo && |evt.port_change
    && !(|(evt.port_change & wake_en.port_change)) |=> st_r == WID_ST_RUN) else $error("port woke");
  chk_cmp_green: assert property (run_ce && power_mode == WID_MODE_GREEN && solo && evt.comparator
    |=> (action != '0) == $past(irq_mask.comparator)) else $error("comparator gating wrong");
  chk_adc_normal: assert property (run_ce && power_mode == WID_MODE_NORMAL && solo && evt.converter
    && !irq_mask.converter |=> action == '0) else $error("converter interrupt unmasked");
  chk_spi_sleep: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.serial_periph
    && wake_en.serial_periph |=> st_r == WID_ST_STARTUP) else $error("serial wake lost");
  chk_hlvd_idle: assert property (run_ce && power_mode == WID_MODE_IDLE && solo && evt.voltage_detect
    |=> (st_r == WID_ST_STARTUP) == $past(wake_en.voltage_detect)) else $error("detector wake wrong");
  chk_uart_no_wake: assert property (run_ce && low_power && solo
    && (evt.uart_tx_done || evt.uart_rx_full || evt.uart_rx_error) |=> st_r == WID_ST_RUN) else $error("uart woke");
  chk_lvr_reset: assert property (run_ce && !low_power && evt.low_volt_reset |=> action.reset)
    else $error("low-voltage reset lost");
  chk_wdt_sleep: assert property (run_ce && low_power && evt.watchdog_timer
    |=> st_r == WID_ST_STARTUP && pend_r.reset) else $error("watchdog wake-reset lost");
  chk_startup_len: assert property (s_wait_end |-> wait_cnt_r == exp_r - {{(CNT_W-1){1'b0}}, 1'b1}
    ##1 wake_done && action != '0) else $error("start-up delay length wrong");
  chk_one_request: assert property ($onehot0(action) and (wake_done |-> action != '0))
    else $error("more than one request");
  chk_pin_reset: assert property (run_ce && !low_power && pin_fall |=> action.reset)
    else $error("reset pin request lost");
  chk_wake_busy: assert property (s_wake_taken |=> startup_busy && !wake_done)
    else $error("start-up wait not entered");
  chk_watch_idle_off: assert property (run_ce && power_mode == WID_MODE_IDLE && solo && evt.watch_timer
    && !global_irq_on |=> st_r == WID_ST_RUN) else $error("watch timer woke with interrupts off");
  chk_spi_vector: assert property (run_ce && power_mode == WID_MODE_SLEEP && solo && evt.serial_periph
    && wake_en.serial_periph && irq_mask.serial_periph && global_irq_on |=> pend_r.vector) else $error("no vector");

endmodule : wid_dispatch

// file: dv/wid_core_model.sv
// model of the core sequencer that takes the dispatch requests
`timescale 1ns/1ps
module wid_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // requests from the dispatch block
  input wire wid_pkg::wid_act_t action,
  input wire logic wake_done,
  // tallies for the bench
  output int n_act,
  output int n_bad
);
  import wid_pkg::*;
  // ==========================================
  // request intake
  // a request is taken in the one cycle it stands, so nothing is latched here
  always @(posedge clk) begin
    if (sys_rst) begin
      n_act <= 0;
      n_bad <= 0;
    end else begin
      if ((|action) === 1'b1) begin
        n_act <= n_act + 1;
      end
      if ($countones(action) > 1 || (wake_done === 1'b1 && (|action) !== 1'b1)) begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule : wid_core_model

// file: dv/tb.sv
// self-checking bench for the wake-up and interrupt dispatch block
`timescale 1ns/1ps
module tb;
  import wid_pkg::*;
  // ==========================================
  // clock, reset and design
  localparam int OSC = 20;
  localparam int W = OSC + 8 + 1;
  localparam int X = OSC + 510 + 1;
  localparam logic [2:0] NO = 3'h0;
  localparam logic [2:0] RES = 3'h1;
  localparam logic [2:0] VEC = 3'h2;
  localparam logic [2:0] RST = 3'h4;
  localparam wid_mode_t SL = WID_MODE_SLEEP;
  localparam wid_mode_t ID = WID_MODE_IDLE;
  localparam wid_mode_t GR = WID_MODE_GREEN;
  localparam wid_mode_t NM = WID_MODE_NORMAL;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic rst_pin_n = 1'b1;
  wid_mode_t power_mode = NM;
  logic global_irq_on = 1'b0;
  wid_cfg_t cfg = '0;
  wid_evt_t evt = '0;
  wid_evt_t e = '0;
  wid_wake_t wake_en = '0;
  wid_mask_t irq_mask = '0;
  wid_act_t action;
  logic wake_done;
  logic startup_busy;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int tests = 0;
  int exp_act = 0;
  int n_act;
  int n_bad;

  always #10 clk = ~clk;

  wid_dispatch #(.OSC_STARTUP_CYC(OSC)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .rst_pin_n(rst_pin_n),
    .power_mode(power_mode), .global_irq_on(global_irq_on), .cfg(cfg), .evt(evt), .wake_en(wake_en),
    .irq_mask(irq_mask), .action(action), .wake_done(wake_done), .startup_busy(startup_busy));

  wid_core_model core_u (.clk(clk), .sys_rst(sys_rst), .action(action), .wake_done(wake_done),
    .n_act(n_act), .n_bad(n_bad));

  // ==========================================
  // checking and stimulus tasks
  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  // only one wake source armed per sleep entry, watchdog quiet unless it is the source
  task automatic clr();
    e = '0;
    wake_en = '0;
    irq_mask = '0;
    cfg = '0;
  endtask : clr

  // one event strobe, then wait a bounded time for the answer
  task automatic go(input wid_mode_t md, input logic gie, input logic [2:0] exp, input int lat);
    int n;
    power_mode = md;
    global_irq_on = gie;
    evt = e;
    @(posedge clk);
    #1;
    evt = '0;
    n = 1;
    if (exp !== NO && (md == SL || md == ID)) check(startup_busy === 1'b1, "start-up not busy");
    while (action === NO && n < lat + 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(action === exp, "wrong request");
    if (exp !== NO) begin
      exp_act++;
      check(n == lat, "wrong latency");
    end
    if (exp !== NO && (md == SL || md == ID)) check(wake_done === 1'b1, "wake not done");
    repeat (2) @(posedge clk);
    #1;
    tests++;
    $display("test %0d done", tests);
  endtask : go

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    clr();
    e.uart_tx_done = 1'b1;
    irq_mask.uart_tx_done = 1'b1;
    go(NM, 1, VEC, 1);
    go(GR, 0, RES, 1);
    go(SL, 1, NO, W);
    irq_mask = '0;
    go(NM, 1, NO, W);
    clr();
    e.base_timer = 1'b1;
    irq_mask.base_timer = 1'b1;
    go(SL, 1, NO, W);
    go(ID, 1, VEC, W);
    cfg.base_timer_counter = 1'b1;
    go(SL, 0, RES, W);
    go(GR, 1, VEC, 1);
    clr();
    e.pwm_period[1] = 1'b1;
    irq_mask.pwm_period[1] = 1'b1;
    go(SL, 1, NO, W);
    go(ID, 0, RES, W);
    clr();
    e.pwm_duty[2] = 1'b1;
    irq_mask.pwm_duty[2] = 1'b1;
    go(SL, 0, NO, W);
    go(ID, 1, VEC, W);
    clr();
    e.gp_timer[0] = 1'b1;
    irq_mask.gp_timer[0] = 1'b1;
    go(SL, 1, NO, W);
    go(ID, 1, VEC, W);
    cfg.gp_timer_counter[0] = 1'b1;
    go(SL, 1, VEC, W);
    clr();
    e.watch_timer = 1'b1;
    irq_mask.watch_timer = 1'b1;
    go(SL, 1, NO, W);
    go(ID, 1, VEC, W);
    go(ID, 0, NO, W);
    go(NM, 0, RES, 1);
    clr();
    e.ext_pin[9] = 1'b1;
    irq_mask.ext_pin[9] = 1'b1;
    go(SL, 1, NO, W);
    go(NM, 0, RES, 1);
    wake_en.ext_pin[9] = 1'b1;
    irq_mask = '0;
    go(SL, 1, RES, W);
    go(GR, 1, NO, W);
    clr();
    e.port_change[3] = 1'b1;
    irq_mask.port_change[3] = 1'b1;
    go(SL, 1, NO, W);
    go(NM, 1, VEC, 1);
    wake_en.port_change[3] = 1'b1;
    go(ID, 1, VEC, W);
    clr();
    e.comparator = 1'b1;
    wake_en.comparator = 1'b1;
    go(ID, 1, RES, W);
    go(SL, 1, RES, W);
    cfg.osc_crystal = 1'b1;
    irq_mask.comparator = 1'b1;
    go(SL, 1, VEC, X);
    go(GR, 1, VEC, 1);
    clr();
    e.converter = 1'b1;
    irq_mask.converter = 1'b1;
    go(SL, 1, NO, W);
    wake_en.converter = 1'b1;
    go(SL, 0, RES, W);
    irq_mask = '0;
    go(NM, 1, NO, W);
    clr();
    e.serial_periph = 1'b1;
    wake_en.serial_periph = 1'b1;
    irq_mask.serial_periph = 1'b1;
    go(SL, 1, VEC, W);
    go(GR, 0, RES, 1);
    clr();
    e.two_wire = 1'b1;
    wake_en.two_wire = 1'b1;
    go(SL, 1, RES, W);
    go(NM, 1, NO, W);
    clr();
    e.voltage_detect = 1'b1;
    irq_mask.voltage_detect = 1'b1;
    go(ID, 1, NO, W);
    go(GR, 1, VEC, 1);
    clr();
    e.uart_rx_full = 1'b1;
    irq_mask.uart_rx_full = 1'b1;
    go(ID, 1, NO, W);
    go(NM, 0, RES, 1);
    clr();
    e.uart_rx_error = 1'b1;
    irq_mask.uart_rx_error = 1'b1;
    go(GR, 1, VEC, 1);
    clr();
    e.low_volt_reset = 1'b1;
    go(NM, 1, RST, 1);
    go(SL, 1, RST, W);
    clr();
    e.watchdog_timer = 1'b1;
    go(GR, 0, RST, 1);
    go(ID, 0, RST, W);
    e.uart_tx_done = 1'b1;
    irq_mask.uart_tx_done = 1'b1;
    go(NM, 1, RST, 1);
    clr();
    // pin passes two sync stages, then the edge detector, before the request
    rst_pin_n = 1'b0;
    go(NM, 0, RST, 3);
    rst_pin_n = 1'b1;
    e.uart_tx_done = 1'b1;
    irq_mask.uart_tx_done = 1'b1;
    // a frozen block takes no decision
    ce = 1'b0;
    go(NM, 1, NO, W);
    ce = 1'b1;
    check(n_act === exp_act, "request tally");
    check(n_bad === 0, "request shape");
    give_verdict();
  end
endmodule : tb
